/* sim/ssc_link_asserts.sv */
// Checker for the serial link that joins the host end to the device end.
`timescale 1ns/1ps
module ssc_link_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic power_enable_pin_a,
  input wire logic power_enable_pin_b,
  input wire logic lock_output_pin
);
  logic [4:0] bit_cnt_ff;
  logic [4:0] nxt_bit_cnt;
  logic sclk_ff;
  // Counts serial clock rises inside a frame, cleared while the strobe is high.
  always_comb begin
    nxt_bit_cnt = bit_cnt_ff;
    if (load_strobe) begin
      nxt_bit_cnt = 5'h00;
    end else if (sclk && !sclk_ff) begin
      nxt_bit_cnt = bit_cnt_ff + 5'h01;
    end
  end
  // Registers the counter and the delayed serial clock.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= 5'h00;
      sclk_ff <= 1'b0;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      sclk_ff <= sclk;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_sclk_idle_low: assert property (load_strobe |-> !sclk)
    else $error("serial clock moved outside a frame");
  a_first_rise_delay: assert property ($fell(load_strobe) |-> !sclk [*6] ##1 sclk)
    else $error("first serial clock rise not one half period after frame start");
  a_sclk_high_width: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
    else $error("serial clock high time wrong");
  a_sclk_low_width: assert property ($fell(sclk) |-> !sclk [*6])
    else $error("serial clock low time too short");
  a_data_stable_high: assert property (sclk |-> $stable(sdata))
    else $error("serial data changed while clock high");
  a_data_moves_fall: assert property (($changed(sdata) && !load_strobe)
    |-> ($fell(sclk) || $fell(load_strobe)))
    else $error("serial data changed away from a clock fall");
  a_twenty_bits: assert property ($rose(load_strobe) |-> bit_cnt_ff == 5'h14)
    else $error("frame did not carry twenty bits");
  a_strobe_after_bit: assert property ($rose(load_strobe)
    |-> ($past(sclk, 7) && !$past(sclk, 6)))
    else $error("strobe rise not one half period after last bit");
  c_frame_end: cover property ($rose(load_strobe));
  c_transmit_pins: cover property (power_enable_pin_a && !power_enable_pin_b);
  c_lock_pulse: cover property ($rose(lock_output_pin));
endmodule : ssc_link_asserts

/* sim/synth_serial_control_and_dividers_tb.sv */
// Testbench joining host and device ends over the serial link.
`timescale 1ns/1ps
module synth_serial_control_and_dividers_tb;
  import ssc_pkg::*;
  logic clock, rst, wr, rd, ref_in, lo_in, synth_enable, lo_buffer_enable;
  logic pump_source, pump_sink, pump_hiz, lock_q;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] pump_current;
  logic [6:0] prescaler_modulus;
  ssc_power_type power_state;
  int failures = 0, checks = 0, lock_rises = 0, n0;
  ssc_link_if ssc_link_if_i ();
  ssc_host ssc_host_i (.clock(clock), .rst(rst), .link(ssc_link_if_i), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ssc_device ssc_device_i (.clock(clock), .rst(rst), .link(ssc_link_if_i), .ref_in(ref_in),
    .lo_in(lo_in), .synth_enable(synth_enable), .lo_buffer_enable(lo_buffer_enable),
    .power_state(power_state), .pump_source(pump_source), .pump_sink(pump_sink),
    .pump_hiz(pump_hiz), .pump_current(pump_current), .prescaler_modulus(prescaler_modulus));
  ssc_link_asserts ssc_link_asserts_i (.clock(clock), .rst(rst), .sclk(ssc_link_if_i.sclk),
    .sdata(ssc_link_if_i.sdata), .load_strobe(ssc_link_if_i.load_strobe),
    .power_enable_pin_a(ssc_link_if_i.power_enable_pin_a),
    .power_enable_pin_b(ssc_link_if_i.power_enable_pin_b),
    .lock_output_pin(ssc_link_if_i.lock_output_pin));
  // Counts rises of the lock pin.
  always @(posedge clock) begin
    lock_q <= ssc_link_if_i.lock_output_pin;
    if (ssc_link_if_i.lock_output_pin === 1'b1 && lock_q === 1'b0) lock_rises++;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // Sends one word and waits until the device has taken it.
  task send(input logic [19:0] w);
    wr_reg(HREG_WORD, {12'h000, w});
    rv = 32'h1;
    for (int i = 0; i < 400 && rv[0] !== 1'b0; i++) rd_reg(HREG_STATUS, rv);
    check(32'(rv[0]), 32'h0);
    repeat (6) @(posedge clock);
  endtask : send
  task pins(input logic [1:0] p);
    wr_reg(HREG_PINS, {30'h0, p});
    repeat (8) @(posedge clock);
  endtask : pins
  // Emits n rising edges on the reference or oscillator input.
  task pulse(input logic sel, input int n);
    repeat (n) begin
      @(posedge clock);
      ref_in <= !sel;
      lo_in <= sel;
      repeat (2) @(posedge clock);
      ref_in <= 1'b0;
      lo_in <= 1'b0;
      @(posedge clock);
    end
  endtask : pulse
  function automatic logic [19:0] mw(input logic en, input logic presc, input logic [1:0] cp,
    input logic sgn, input logic [2:0] ld, input logic [1:0] tst);
    logic [15:0] m;
    m = 16'h0000;
    m[MB_EN] = en;
    m[MB_PRESC] = presc;
    m[MB_CP_LO +: 2] = cp;
    m[MB_SIGN0] = sgn;
    m[MB_LD0] = ld[0];
    m[MB_LD1] = ld[1];
    m[MB_LD2] = ld[2];
    m[MB_TEST0 +: 2] = tst;
    return {2'h0, m, ADDR_MODE};
  endfunction : mw
  task t_reset;
    check(32'(power_state), 32'(PWR_DISABLED));
    check(32'({pump_hiz, synth_enable, ssc_link_if_i.load_strobe}), 32'h5);
    check(32'(prescaler_modulus), 32'(PRESC_LOW));
    check(32'(ssc_link_if_i.lock_output_pin), 32'h0);
    $display("test reset done");
  endtask : t_reset
  // Walks every pin combination with the enable bit set, then clears it.
  task t_power;
    ssc_power_type exp [4];
    exp = '{PWR_DOWN, PWR_TRANSMIT, PWR_STANDBY, PWR_RECEIVE};
    send(mw(1'b1, 1'b0, 2'h0, 1'b0, 3'h2, 2'h0));
    for (int i = 0; i < 4; i++) begin
      pins(2'(i));
      check(32'(power_state), 32'(exp[i]));
      check(32'({synth_enable, lo_buffer_enable}), (i != 0) ? 32'h3 : 32'h0);
    end
    send(mw(1'b0, 1'b0, 2'h0, 1'b0, 3'h2, 2'h0));
    check(32'(power_state), 32'(PWR_DISABLED));
    check(32'({synth_enable, lo_buffer_enable}), 32'h1);
    $display("test power done");
  endtask : t_power
  // Every pump current, test code and both prescaler ratios.
  task t_fields;
    for (int i = 0; i < 4; i++) begin
      send(mw(1'b1, i[0], 2'(i), 1'b0, 3'h2, 2'(i)));
      check(32'(pump_current), 32'(i));
      check(32'(prescaler_modulus), i[0] ? 32'(PRESC_HIGH) : 32'(PRESC_LOW));
      check(32'({pump_source, pump_sink, pump_hiz}), 32'({i == 1, i == 2, i == 3}));
      check(32'(ssc_link_if_i.lock_output_pin), 32'h0);
    end
    // Read back selection shows the most significant shifted bit.
    send(mw(1'b1, 1'b1, 2'h3, 1'b0, 3'h4, 2'h3));
    check(32'(ssc_link_if_i.lock_output_pin), 32'h0);
    send({1'b1, 17'h00000, ADDR_NONE});
    check(32'(ssc_link_if_i.lock_output_pin), 32'h1);
    $display("test fields done");
  endtask : t_fields
  // Unused address is dropped and values survive power-down.
  task t_retain;
    send({18'h00000, ADDR_NONE});
    check(32'({synth_enable, pump_current}), 32'h7);
    check(32'(ssc_link_if_i.lock_output_pin), 32'h0);
    rd_reg(HREG_WORD, rv);
    check(rv, 32'(ADDR_NONE));
    rd_reg(4'hC, rv);
    check(rv, 32'h0);
    pins(2'h0);
    check(32'(power_state), 32'(PWR_DOWN));
    pins(2'h3);
    check(32'(power_state), 32'(PWR_RECEIVE));
    check(32'({pump_current, prescaler_modulus}), 32'({2'h3, PRESC_HIGH}));
    $display("test retain done");
  endtask : t_retain
  // Reference divide by 3 and oscillator divide by 32*3+1 seen on the lock pin.
  task t_divider;
    send({3'h0, 15'h0003, ADDR_REF});
    send({11'h003, 7'h01, ADDR_OSC});
    send(mw(1'b1, 1'b0, 2'h0, 1'b0, 3'h6, 2'h0));
    n0 = lock_rises;
    pulse(1'b0, 12);
    repeat (8) @(posedge clock);
    check(32'(lock_rises - n0), 32'h4);
    check(32'({pump_source, pump_sink}), 32'h2);
    send(mw(1'b1, 1'b0, 2'h0, 1'b1, 3'h7, 2'h0));
    check(32'({pump_source, pump_sink}), 32'h1);
    // Power down and up again so the counters start from the loaded counts.
    pins(2'h0);
    pins(2'h3);
    n0 = lock_rises;
    pulse(1'b1, 96);
    repeat (8) @(posedge clock);
    check(32'(lock_rises - n0), 32'h0);
    pulse(1'b1, 1);
    repeat (8) @(posedge clock);
    check(32'(lock_rises - n0), 32'h1);
    pulse(1'b1, 97);
    repeat (8) @(posedge clock);
    check(32'(lock_rises - n0), 32'h2);
    $display("test divider done");
  endtask : t_divider
  task end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #300000;
    failures++;
    end_of_test;
  end
  initial begin
    {rst, wr, rd, ref_in, lo_in} = 5'h10;
    addr = 4'h0;
    wdata = 32'h0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1 t_reset;
    t_power;
    t_fields;
    t_retain;
    t_divider;
    end_of_test;
  end
endmodule : synth_serial_control_and_dividers_tb

/* verilog/ssc_device.sv */
// Device end: serial loader, power decode, dividers and pump control.
//
// What this block does
// - Sample data on serial clock rise, MSB first.
// - Shift bits only while load strobe low.
// - Strobe rise loads word into addressed register.
// - Keep all programmed values across power-down.
// - Pins low, enable set: power-down, port alive.
// - Enable set: pins select receive, transmit, standby.
// - Enable clear disables synthesizer regardless of pins.
// - Synth enable is bit AND pin OR.
// - Address 00 loads 15-bit reference divide value.
// - Address 10 loads swallow and main counts.
// - Address 01 loads mode fields; gaps stored as sent.
// - Divide reference input by reference value.
// - Divide oscillator by prescaler times main plus swallow.
// - Mode bit zero is the synthesizer enable.
// - Prescaler select picks 32/33 or 64/65.
// - Two-bit field selects pump current step.
// - Polarity code picks when pump sources current.
// - Lock pin select routes one of five sources.
// - Test field forces source, sink or high impedance.
// - Host keeps reference value within 3..32767.
// - Host keeps main count within 3..2047.
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module ssc_device (
  input wire logic clock,
  input wire logic rst,
  ssc_link_if.device link,
  input wire logic ref_in,
  input wire logic lo_in,
  output logic synth_enable,
  output logic lo_buffer_enable,
  output ssc_pkg::ssc_power_type power_state,
  output logic pump_source,
  output logic pump_sink,
  output logic pump_hiz,
  output logic [1:0] pump_current,
  output logic [6:0] prescaler_modulus
);
  import ssc_pkg::*;

  // Positions of the sampled inputs in the synchroniser vectors.
  localparam int IN_W = 7;
  localparam int I_SCK = 0;
  localparam int I_DAT = 1;
  localparam int I_LE = 2;
  localparam int I_PA = 3;
  localparam int I_PB = 4;
  localparam int I_REF = 5;
  localparam int I_LO = 6;
  localparam logic [IN_W-1:0] SYNC_IDLE = 7'h04; // Strobe idles high; no false load.

  typedef struct packed {
    logic [IN_W-1:0] sync1;
    logic [IN_W-1:0] sync2;
    logic [IN_W-1:0] prev;
    logic [WORD_W-1:0] shift;
    logic [R_W-1:0] ref_div;
    logic [A_W-1:0] swallow;
    logic [B_W-1:0] main;
    logic [MODE_W-1:0] mode;
    logic [R_W-1:0] ref_cnt;
    logic ref_wave;
    logic [6:0] pre_cnt;
    logic [A_W-1:0] swl_cnt;
    logic [B_W-1:0] main_cnt;
    logic lo_wave;
    logic up;
    logic dn;
    logic [7:0] err_cnt;
    logic locked;
    logic synth_en;
    logic lo_buf_en;
    ssc_power_type pwr;
    logic src;
    logic snk;
    logic hiz;
    logic [1:0] cur;
    logic [6:0] presc;
    logic lock_pin;
  } ssc_dev_state_type;

  ssc_dev_state_type cur_ff;
  ssc_dev_state_type nxt_st;
  // Low modulus of the dual-modulus prescaler for a select bit.
  function automatic logic [6:0] low_modulus(input logic sel);
    low_modulus = sel ? PRESC_HIGH : PRESC_LOW;
  endfunction : low_modulus
  // Next state of the whole device.
  always_comb begin
    logic [IN_W-1:0] rise;
    logic [1:0] addr;
    logic ref_pulse;
    logic lo_pulse;
    logic [6:0] modulus;
    logic pump_pos;
    logic pump_neg;
    rise = '0;
    addr = '0;
    ref_pulse = 1'b0;
    lo_pulse = 1'b0;
    modulus = '0;
    pump_pos = 1'b0;
    pump_neg = 1'b0;
    nxt_st = cur_ff;
    // Two flip-flops before any logic reads a pin.
    nxt_st.sync1 = {lo_in, ref_in, link.power_enable_pin_b, link.power_enable_pin_a,
                    link.load_strobe, link.sdata, link.sclk};
    nxt_st.sync2 = cur_ff.sync1;
    nxt_st.prev = cur_ff.sync2;
    rise = cur_ff.sync2 & ~cur_ff.prev;
    // shift on rise, MSB first; only while strobe low.
    if (rise[I_SCK] && !cur_ff.sync2[I_LE]) begin
      nxt_st.shift = {cur_ff.shift[WORD_W-2:0], cur_ff.sync2[I_DAT]};
    end
    // address from last two bits; load on strobe rise.
    addr = {cur_ff.shift[1], cur_ff.shift[0]};
    if (rise[I_LE]) begin
      unique case (addr)
        ADDR_REF: nxt_st.ref_div = cur_ff.shift[R_LSB +: R_W];
        ADDR_OSC: begin
          nxt_st.swallow = cur_ff.shift[A_LSB +: A_W];
          nxt_st.main = cur_ff.shift[B_LSB +: B_W];
        end
        // mode fields, reserved bits stored as sent.
        ADDR_MODE: nxt_st.mode = cur_ff.shift[MODE_LSB +: MODE_W];
        // undefined address leaves every register alone.
        ADDR_NONE: nxt_st.mode = cur_ff.mode;
      endcase
    end
    // synth enable is bit AND pin OR; buffers follow pins.
    // mode bit zero is the enable.
    nxt_st.lo_buf_en = cur_ff.sync2[I_PA] | cur_ff.sync2[I_PB];
    nxt_st.synth_en = cur_ff.mode[MB_EN] & (cur_ff.sync2[I_PA] | cur_ff.sync2[I_PB]);
    // power state decode from enable bit and pins.
    if (!cur_ff.mode[MB_EN]) begin
      nxt_st.pwr = PWR_DISABLED;
    end else begin
      unique case ({cur_ff.sync2[I_PA], cur_ff.sync2[I_PB]})
        2'b00: nxt_st.pwr = PWR_DOWN;
        2'b11: nxt_st.pwr = PWR_RECEIVE;
        2'b10: nxt_st.pwr = PWR_TRANSMIT;
        2'b01: nxt_st.pwr = PWR_STANDBY;
      endcase
    end
    // prescaler select; one extra count while swallowing.
    modulus = low_modulus(cur_ff.mode[MB_PRESC]);
    if (cur_ff.swl_cnt != '0) begin
      modulus = modulus + 7'h01;
    end
    nxt_st.presc = low_modulus(cur_ff.mode[MB_PRESC]);
    if (!cur_ff.synth_en) begin
      // dividers idle but programmed words are kept.
      nxt_st.ref_cnt = '0;
      nxt_st.ref_wave = 1'b0;
      nxt_st.pre_cnt = '0;
      nxt_st.swl_cnt = cur_ff.swallow;
      nxt_st.main_cnt = cur_ff.main;
      nxt_st.lo_wave = 1'b0;
      nxt_st.up = 1'b0;
      nxt_st.dn = 1'b0;
      nxt_st.err_cnt = '0;
      nxt_st.locked = 1'b0;
    end else begin
      // reference divider, one pulse every ref_div input edges.
      // a value below three gives a meaningless ratio.
      if (rise[I_REF]) begin
        if (cur_ff.ref_cnt + 15'h0001 >= cur_ff.ref_div) begin
          nxt_st.ref_cnt = '0;
          ref_pulse = 1'b1;
        end else begin
          nxt_st.ref_cnt = cur_ff.ref_cnt + 15'h0001;
        end
        nxt_st.ref_wave = ref_pulse;
      end
      // swallow and main counters around the prescaler.
      // main count must stay at least three and above swallow.
      if (rise[I_LO]) begin
        if (cur_ff.pre_cnt + 7'h01 >= modulus) begin
          nxt_st.pre_cnt = '0;
          if (cur_ff.swl_cnt != '0) begin
            nxt_st.swl_cnt = cur_ff.swl_cnt - 7'h01;
          end
          if (cur_ff.main_cnt <= 11'h001) begin
            nxt_st.main_cnt = cur_ff.main;
            nxt_st.swl_cnt = cur_ff.swallow;
            lo_pulse = 1'b1;
          end else begin
            nxt_st.main_cnt = cur_ff.main_cnt - 11'h001;
          end
        end else begin
          nxt_st.pre_cnt = cur_ff.pre_cnt + 7'h01;
        end
        nxt_st.lo_wave = lo_pulse;
      end
      // Phase detector: reference first means the oscillator is slow.
      nxt_st.up = cur_ff.up | ref_pulse;
      nxt_st.dn = cur_ff.dn | lo_pulse;
      if (cur_ff.up ^ cur_ff.dn) begin
        if (cur_ff.err_cnt != 8'hFF) begin
          nxt_st.err_cnt = cur_ff.err_cnt + 8'h01;
        end
      end
      if (nxt_st.up && nxt_st.dn) begin
        nxt_st.up = 1'b0;
        nxt_st.dn = 1'b0;
        nxt_st.locked = (cur_ff.err_cnt <= LOCK_WINDOW_CYC);
        nxt_st.err_cnt = '0;
      end
    end
    // polarity picks which detector output sources current.
    pump_pos = cur_ff.mode[MB_SIGN0] ? cur_ff.dn : cur_ff.up;
    pump_neg = cur_ff.mode[MB_SIGN0] ? cur_ff.up : cur_ff.dn;
    // current step code, upper bit first.
    nxt_st.cur = cur_ff.mode[MB_CP_LO +: 2];
    nxt_st.src = 1'b0;
    nxt_st.snk = 1'b0;
    nxt_st.hiz = 1'b0;
    if (!cur_ff.synth_en) begin
      nxt_st.hiz = 1'b1;
    end else begin
      unique case ({cur_ff.mode[MB_TEST1], cur_ff.mode[MB_TEST0]})
        2'b00: begin
          nxt_st.src = pump_pos;
          nxt_st.snk = pump_neg;
        end
        2'b01: nxt_st.src = 1'b1;
        2'b10: nxt_st.snk = 1'b1;
        2'b11: nxt_st.hiz = 1'b1;
      endcase
    end
    unique case ({cur_ff.mode[MB_LD2], cur_ff.mode[MB_LD1]})
      2'b00: nxt_st.lock_pin = cur_ff.locked;
      2'b01: nxt_st.lock_pin = 1'b0;
      2'b10: nxt_st.lock_pin = cur_ff.shift[WORD_W-1];
      2'b11: nxt_st.lock_pin = cur_ff.mode[MB_LD0] ? cur_ff.lo_wave : cur_ff.ref_wave;
    endcase
  end

  // State register; only reset clears the programmed words.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_ff <= '{sync1: SYNC_IDLE, sync2: SYNC_IDLE, prev: SYNC_IDLE, shift: '0,
                  ref_div: RESET_REF, swallow: RESET_SWALLOW, main: RESET_MAIN,
                  mode: RESET_MODE, ref_cnt: '0, ref_wave: 1'b0, pre_cnt: '0,
                  swl_cnt: '0, main_cnt: '0, lo_wave: 1'b0, up: 1'b0, dn: 1'b0,
                  err_cnt: '0, locked: 1'b0, synth_en: 1'b0, lo_buf_en: 1'b0,
                  pwr: PWR_DISABLED, src: 1'b0, snk: 1'b0, hiz: 1'b1, cur: '0,
                  presc: PRESC_LOW, lock_pin: 1'b0};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state register.
  assign synth_enable = cur_ff.synth_en;
  assign lo_buffer_enable = cur_ff.lo_buf_en;
  assign power_state = cur_ff.pwr;
  assign pump_source = cur_ff.src;
  assign pump_sink = cur_ff.snk;
  assign pump_hiz = cur_ff.hiz;
  assign pump_current = cur_ff.cur;
  assign prescaler_modulus = cur_ff.presc;
  assign link.lock_output_pin = cur_ff.lock_pin;
endmodule : ssc_device

/* verilog/ssc_host.sv */
// Host end: register port that sends 20-bit words over the serial link.
`timescale 1ns/1ps
module ssc_host (
  input wire logic clock,
  input wire logic rst,
  ssc_link_if.host link,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import ssc_pkg::*;

  typedef enum {H_IDLE, H_LOW, H_HIGH, H_LATCH, H_GAP} ssc_host_fsm_type;

  typedef struct packed {
    logic lock_s1;
    logic lock_s2;
    ssc_host_fsm_type fsm;
    logic [7:0] tick_cnt;
    logic [4:0] bit_cnt;
    logic [WORD_W-1:0] word;
    logic sclk;
    logic sdata;
    logic le;
    logic pa;
    logic pb;
    logic [31:0] rdata;
  } ssc_host_state_type;

  ssc_host_state_type cur_ff;
  ssc_host_state_type nxt_st;

  // Next state: register port, half-period divider and shift sequencer.
  always_comb begin
    logic tick;
    logic busy;
    tick = 1'b0;
    busy = 1'b0;
    nxt_st = cur_ff;
    nxt_st.lock_s1 = link.lock_output_pin;
    nxt_st.lock_s2 = cur_ff.lock_s1;
    busy = (cur_ff.fsm != H_IDLE);

    // Divider makes one enable pulse per serial half period.
    tick = (cur_ff.tick_cnt == 8'(SCLK_HALF_CYC - 1));
    nxt_st.tick_cnt = tick ? 8'h00 : cur_ff.tick_cnt + 8'h01;

    unique case (cur_ff.fsm)
      H_IDLE: begin
        nxt_st.tick_cnt = 8'h00;
        // strobe falls before the first bit.
        if (wr && addr == HREG_WORD) begin
          nxt_st.word = wdata[WORD_W-1:0];
          nxt_st.le = 1'b0;
          nxt_st.sclk = 1'b0;
          nxt_st.sdata = wdata[WORD_W-1];
          nxt_st.bit_cnt = 5'h00;
          nxt_st.fsm = H_LOW;
        end
      end
      H_LOW: if (tick) begin
        nxt_st.sclk = 1'b1;
        nxt_st.fsm = H_HIGH;
      end
      H_HIGH: if (tick) begin
        nxt_st.sclk = 1'b0;
        if (cur_ff.bit_cnt == 5'(WORD_W - 1)) begin
          nxt_st.fsm = H_LATCH;
        end else begin
          nxt_st.bit_cnt = cur_ff.bit_cnt + 5'h01;
          nxt_st.sdata = cur_ff.word[5'(WORD_W - 2) - cur_ff.bit_cnt];
          nxt_st.fsm = H_LOW;
        end
      end
      // strobe rises a half period after the last bit.
      H_LATCH: if (tick) begin
        nxt_st.le = 1'b1;
        nxt_st.fsm = H_GAP;
      end
      H_GAP: if (tick) begin
        nxt_st.fsm = H_IDLE;
      end
    endcase

    // Pin register write.
    if (wr && addr == HREG_PINS) begin
      nxt_st.pa = wdata[0];
      nxt_st.pb = wdata[1];
    end

    // Read data stands in the cycle after the strobe.
    if (rd) begin
      unique case (addr)
        HREG_WORD: nxt_st.rdata = {12'h000, cur_ff.word};
        HREG_STATUS: nxt_st.rdata = {30'h00000000, cur_ff.lock_s2, busy};
        HREG_PINS: nxt_st.rdata = {30'h00000000, cur_ff.pb, cur_ff.pa};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_ff <= '{lock_s1: 1'b0, lock_s2: 1'b0, fsm: H_IDLE, tick_cnt: '0,
                  bit_cnt: '0, word: '0, sclk: 1'b0, sdata: 1'b0, le: 1'b1,
                  pa: 1'b0, pb: 1'b0, rdata: '0};
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops.
  assign link.sclk = cur_ff.sclk;
  assign link.sdata = cur_ff.sdata;
  assign link.load_strobe = cur_ff.le;
  assign link.power_enable_pin_a = cur_ff.pa;
  assign link.power_enable_pin_b = cur_ff.pb;
  assign rdata = cur_ff.rdata;
endmodule : ssc_host

/* verilog/ssc_link_if.sv */
// Three-wire serial link and power pins between host and device.
`timescale 1ns/1ps
interface ssc_link_if;
  logic sclk;
  logic sdata;
  logic load_strobe;
  logic power_enable_pin_a;
  logic power_enable_pin_b;
  logic lock_output_pin;
  modport device (
    input sclk,
    input sdata,
    input load_strobe,
    input power_enable_pin_a,
    input power_enable_pin_b,
    output lock_output_pin
  );
  modport host (
    output sclk,
    output sdata,
    output load_strobe,
    output power_enable_pin_a,
    output power_enable_pin_b,
    input lock_output_pin
  );
endinterface : ssc_link_if

/* verilog/ssc_pkg.sv */
// Shared constants and types for the synthesizer serial control pair.
package ssc_pkg;
  // Serial word and field widths.
  localparam int WORD_W = 20;
  localparam int R_W = 15;
  localparam int A_W = 7;
  localparam int B_W = 11;
  localparam int MODE_W = 16;
  // Address code formed as {position 1, position 0} of the shifted word.
  localparam logic [1:0] ADDR_REF = 2'h0;
  localparam logic [1:0] ADDR_MODE = 2'h1;
  localparam logic [1:0] ADDR_OSC = 2'h2;
  localparam logic [1:0] ADDR_NONE = 2'h3;
  // Field positions in the shift register, bit 0 is the last bit shifted.
  localparam int R_LSB = 2;
  localparam int A_LSB = 2;
  localparam int B_LSB = 9;
  localparam int MODE_LSB = 2;
  // Bit positions inside the stored mode word.
  localparam int MB_EN = 0;
  localparam int MB_PRESC = 2;
  localparam int MB_CP_LO = 3;
  localparam int MB_SIGN0 = 5;
  localparam int MB_SIGN1 = 6;
  localparam int MB_LD0 = 7;
  localparam int MB_LD1 = 8;
  localparam int MB_LD2 = 13;
  localparam int MB_TEST0 = 14;
  localparam int MB_TEST1 = 15;
  // Prescaler low modulus for each select value.
  localparam logic [6:0] PRESC_LOW = 7'h20;
  localparam logic [6:0] PRESC_HIGH = 7'h40;
  // Reset values of the stored words.
  localparam logic [R_W-1:0] RESET_REF = 15'h0000;
  localparam logic [A_W-1:0] RESET_SWALLOW = 7'h00;
  localparam logic [B_W-1:0] RESET_MAIN = 11'h000;
  localparam logic [MODE_W-1:0] RESET_MODE = 16'h0000;
  // Lock is declared when the phase error pulse lasts at most this many cycles.
  localparam logic [7:0] LOCK_WINDOW_CYC = 8'h04;
  // Host timing: system clock and serial clock half period.
  localparam int CLK_NS = 10;
  localparam int SCLK_HALF_NS = 60;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  // Host register map.
  localparam logic [3:0] HREG_WORD = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_PINS = 4'h8;
  // Decoded power state of the device.
  typedef enum logic [2:0] {
    PWR_DISABLED,
    PWR_DOWN,
    PWR_RECEIVE,
    PWR_TRANSMIT,
    PWR_STANDBY
  } ssc_power_type;
endpackage : ssc_pkg
